// ===== scci_top.sv
// pseudo-command interpreter for secure memory cards, apb register access
//
// Contract
// - verify: FF 20 08 0A 02 plus code
// - present, clear one counter bit, erase
// - status 9000 ok, 6300 no retries
// - fuse burn: 05 00 00 04, four bytes
// - burned fuse stays burned, never restored
// - info query: FF 09 00 00 10
// - reply: firmware, limits, bitmap, selection, state
// - bitmap marks selectable supported types
// - selection 00 means none chosen
// - state 00 absent, 01 inserted, 03 powered
// - type codes 00-09, 0C, 0D
// - error codes 01 to 08
// - counter length locates bit to clear
// - other commands report 9000 on success
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "scci_defs.svh"
module scci_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        card_present,
  input  wire logic        card_powered,
  output logic             card_req,
  output logic      [2:0]  card_op,
  output logic      [15:0] card_addr,
  output logic      [15:0] card_wdata,
  output logic      [7:0]  card_aux,
  input  wire logic        card_ack,
  input  wire logic        card_fail,
  input  wire logic [7:0]  card_rdata
);

  logic [31:0]         hdr_ff;
  logic [7:0]          len_ff;
  logic [31:0]         data_ff;
  logic [7:0]          card_sel_ff;
  logic [2:0]          irq_stat_ff;
  logic [2:0]          irq_mask_ff;
  logic                fuse_burned_ff;
  logic [15:0]         sw_ff;
  logic [7:0]          err_ff;
  logic [7:0]          cnt_ff;
  logic [3:0]          bit_idx_ff;
  logic [31:0]         prdata_ff;
  logic                pready_ff;
  logic                pslverr_ff;
  logic                irq_ff;
  logic                card_req_ff;
  logic [2:0]          card_op_ff;
  logic [15:0]         card_addr_ff;
  logic [15:0]         card_wdata_ff;
  logic [7:0]          card_aux_ff;
  scci_pkg::scci_state_t state_ff;
  scci_pkg::scci_state_t nxt_state;

  logic [7:0]   cla;
  logic [7:0]   ins;
  logic [7:0]   p1;
  logic [7:0]   p2;
  logic         setup;
  logic         wr_access;
  logic         rd_access;
  logic         go;
  logic         busy;
  logic         card_done;
  logic [127:0] reply;
  logic [7:0]   card_stat;
  logic [2:0]   evt;

  // index of the lowest one bit within the first len bits, 8 when none
  function automatic logic [3:0] first_one(input logic [7:0] v, input logic [7:0] len);
    logic [3:0] idx;
    idx = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i] && (8'(i) < len)) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // only listed card type codes may be selected
  function automatic logic type_valid(input logic [7:0] t);
    return (t <= `SCCI_TYPE_MAX_SEQ) || (t == `SCCI_TYPE_MCU_T0) ||
           (t == `SCCI_TYPE_MCU_T1);
  endfunction

  assign cla       = hdr_ff[7:0];
  assign ins       = hdr_ff[15:8];
  assign p1        = hdr_ff[23:16];
  assign p2        = hdr_ff[31:24];
  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pready_ff & pwrite;
  assign rd_access = psel & penable & pready_ff & ~pwrite;
  assign busy      = (state_ff != scci_pkg::SCCI_IDLE);
  assign go        = wr_access && (paddr == `SCCI_OFS_CTRL) && pwdata[0] && !busy;
  assign card_done = card_req_ff & card_ack;

  // card state byte
  assign card_stat = !card_present ? `SCCI_STAT_ABSENT :
                     card_powered  ? `SCCI_STAT_POWERED :
                                     `SCCI_STAT_INSERTED;

  // reply record, first byte in the low lane of the first word
  assign reply = {card_stat,
                  card_sel_ff,
                  `SCCI_TYPE_BITMAP,
                  `SCCI_MAX_RESP,
                  `SCCI_MAX_CMD,
                  `SCCI_FW_VERSION};

  // apb: answer computed in setup, so every access phase has pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      if (setup) begin
        case (paddr)
          `SCCI_OFS_CTRL:     prdata_ff <= {31'h0000_0000, busy};
          `SCCI_OFS_HDR:      prdata_ff <= hdr_ff;
          `SCCI_OFS_LEN:      prdata_ff <= {24'h00_0000, len_ff};
          `SCCI_OFS_DATA:     prdata_ff <= data_ff;
          `SCCI_OFS_STATUS:   prdata_ff <= {fuse_burned_ff, 7'h00, err_ff, sw_ff};
          `SCCI_OFS_CARD_SEL: prdata_ff <= {24'h00_0000, card_sel_ff};
          `SCCI_OFS_IRQ_STAT: prdata_ff <= {29'h0000_0000, irq_stat_ff};
          `SCCI_OFS_IRQ_MASK: prdata_ff <= {29'h0000_0000, irq_mask_ff};
          `SCCI_OFS_REPLY0:   prdata_ff <= reply[31:0];
          `SCCI_OFS_REPLY1:   prdata_ff <= reply[63:32];
          `SCCI_OFS_REPLY2:   prdata_ff <= reply[95:64];
          `SCCI_OFS_REPLY3:   prdata_ff <= reply[127:96];
          default:            pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  // command buffer; frozen while a command runs so the card sees stable fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_ff  <= 32'h0000_0000;
      len_ff  <= 8'h00;
      data_ff <= 32'h0000_0000;
    end else if (wr_access && !busy) begin
      case (paddr)
        `SCCI_OFS_HDR:  hdr_ff <= pwdata;
        `SCCI_OFS_LEN:  len_ff <= pwdata[7:0];
        `SCCI_OFS_DATA: data_ff <= pwdata;
        default: ;
      endcase
    end
  end

  // card type selection; invalid codes are dropped, keeping the old one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_sel_ff <= `SCCI_TYPE_NONE;
    end else if (wr_access && (paddr == `SCCI_OFS_CARD_SEL) && type_valid(pwdata[7:0])) begin
      card_sel_ff <= pwdata[7:0];
    end
  end

  // interpreter sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      scci_pkg::SCCI_IDLE:      if (go) nxt_state = scci_pkg::SCCI_DECODE;
      scci_pkg::SCCI_DECODE: begin
        nxt_state = scci_pkg::SCCI_FINISH;
        if (cla == `SCCI_CLA && ins == `SCCI_INS_VERIFY && card_present &&
            p1 == `SCCI_VER_CNT_LEN && p2 == `SCCI_VER_KEY_ADDR && len_ff == `SCCI_VER_LEN) begin
          nxt_state = scci_pkg::SCCI_PRESENT;
        end
        if (cla == `SCCI_CLA && ins == `SCCI_INS_FUSE && card_present && p1 == 8'h00 &&
            p2 == 8'h00 && len_ff == `SCCI_FUSE_LEN && data_ff[23:16] == `SCCI_FUSE_PIN_ON) begin
          nxt_state = scci_pkg::SCCI_FUSE;
        end
      end
      scci_pkg::SCCI_PRESENT:   if (card_done) nxt_state = card_fail ? scci_pkg::SCCI_FINISH
                                                                     : scci_pkg::SCCI_READ_CNT;
      scci_pkg::SCCI_READ_CNT:  if (card_done) begin
        // no one bit left: skip the write and the erase, go straight to finish
        nxt_state = (card_fail || first_one(card_rdata, p1) == 4'h8) ? scci_pkg::SCCI_FINISH
                                                                      : scci_pkg::SCCI_WRITE_CNT;
      end
      scci_pkg::SCCI_WRITE_CNT: if (card_done) nxt_state = card_fail ? scci_pkg::SCCI_FINISH
                                                                     : scci_pkg::SCCI_ERASE_CNT;
      scci_pkg::SCCI_ERASE_CNT: if (card_done) nxt_state = scci_pkg::SCCI_FINISH;
      scci_pkg::SCCI_FUSE:      if (card_done) nxt_state = scci_pkg::SCCI_FINISH;
      scci_pkg::SCCI_FINISH:    nxt_state = scci_pkg::SCCI_IDLE;
      default:                  nxt_state = scci_pkg::SCCI_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= scci_pkg::SCCI_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // card requests: one request held until the card acknowledges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_req_ff   <= 1'b0;
      card_op_ff    <= 3'h0;
      card_addr_ff  <= 16'h0000;
      card_wdata_ff <= 16'h0000;
      card_aux_ff   <= 8'h00;
    end else begin
      if (card_done) begin
        card_req_ff <= 1'b0;
      end
      if (state_ff != nxt_state) begin
        case (nxt_state)
          scci_pkg::SCCI_PRESENT: begin
            card_req_ff   <= 1'b1;
            card_op_ff    <= 3'(scci_pkg::SCCI_OP_PRESENT);
            card_addr_ff  <= {8'h00, p2};
            card_wdata_ff <= data_ff[15:0];
          end
          scci_pkg::SCCI_READ_CNT: begin
            card_req_ff  <= 1'b1;
            card_op_ff   <= 3'(scci_pkg::SCCI_OP_READ_CNT);
            card_aux_ff  <= p1;
          end
          scci_pkg::SCCI_WRITE_CNT: begin
            card_req_ff   <= 1'b1;
            card_op_ff    <= 3'(scci_pkg::SCCI_OP_WRITE_CNT);
            card_wdata_ff <= {12'h000, first_one(card_rdata, p1)};
          end
          scci_pkg::SCCI_ERASE_CNT: begin
            card_req_ff <= 1'b1;
            card_op_ff  <= 3'(scci_pkg::SCCI_OP_ERASE_CNT);
          end
          scci_pkg::SCCI_FUSE: begin
            card_req_ff   <= 1'b1;
            card_op_ff    <= 3'(scci_pkg::SCCI_OP_FUSE);
            card_addr_ff  <= {data_ff[7:0], data_ff[15:8]};
            card_wdata_ff <= {data_ff[23:16], data_ff[31:24]};
          end
          default: ;
        endcase
      end
    end
  end

  // counter snapshot at the counter read; the retry decision uses card_rdata directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff     <= 8'h00;
      bit_idx_ff <= 4'h0;
    end else if (state_ff == scci_pkg::SCCI_READ_CNT && card_done) begin
      cnt_ff     <= card_rdata;
      bit_idx_ff <= first_one(card_rdata, p1);
    end
  end

  // status words and error code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_ff  <= 16'h0000;
      err_ff <= `SCCI_ERR_NONE;
    end else begin
      if (state_ff == scci_pkg::SCCI_DECODE) begin
        sw_ff  <= `SCCI_SW_OK;
        err_ff <= `SCCI_ERR_NONE;
        if (ins == `SCCI_INS_INFO) begin
          if (cla != `SCCI_CLA || p1 != 8'h00 || p2 != 8'h00 || len_ff != `SCCI_INFO_LEN) begin
            err_ff <= `SCCI_ERR_FORMAT;
          end
        end else if (ins == `SCCI_INS_VERIFY || ins == `SCCI_INS_FUSE) begin
          if (nxt_state == scci_pkg::SCCI_FINISH) begin
            err_ff <= card_present ? `SCCI_ERR_FORMAT : `SCCI_ERR_CARD_OP;
          end
        end else begin
          err_ff <= `SCCI_ERR_UNKNOWN;
        end
      end
      if (card_done && card_fail) begin
        err_ff <= `SCCI_ERR_CARD_OP;
      end
      if (state_ff == scci_pkg::SCCI_READ_CNT && card_done && !card_fail &&
          first_one(card_rdata, p1) == 4'h8) begin
        sw_ff <= `SCCI_SW_NO_RETRY;
      end
      if (state_ff == scci_pkg::SCCI_FINISH && err_ff != `SCCI_ERR_NONE) begin
        sw_ff <= 16'h0000;
      end
    end
  end

  // burned fuse is sticky until power-on reset, nothing clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_burned_ff <= 1'b0;
    end else if (state_ff == scci_pkg::SCCI_FUSE && card_done && !card_fail) begin
      fuse_burned_ff <= 1'b1;
    end
  end

  // interrupt events: done, error, fuse burned
  assign evt[`SCCI_IRQ_DONE]  = (state_ff == scci_pkg::SCCI_FINISH);
  assign evt[`SCCI_IRQ_ERROR] = (state_ff == scci_pkg::SCCI_FINISH) && (err_ff != `SCCI_ERR_NONE);
  assign evt[`SCCI_IRQ_FUSE]  = (state_ff == scci_pkg::SCCI_FUSE) && card_done && !card_fail;

  // read clears only what it reported, so a set at the setup edge survives; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 3'h0;
      irq_mask_ff <= 3'h0;
      irq_ff      <= 1'b0;
    end else begin
      if (rd_access && paddr == `SCCI_OFS_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~prdata_ff[2:0]) | evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | evt;
      end
      if (wr_access && paddr == `SCCI_OFS_IRQ_MASK) begin
        irq_mask_ff <= pwdata[2:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign irq        = irq_ff;
  assign card_req   = card_req_ff;
  assign card_op    = card_op_ff;
  assign card_addr  = card_addr_ff;
  assign card_wdata = card_wdata_ff;
  assign card_aux   = card_aux_ff;

endmodule
`default_nettype wire

// ===== scci_defs.svh
// offsets, field values and reset values for the card command interpreter
`ifndef SCCI_DEFS_SVH
`define SCCI_DEFS_SVH
`define SCCI_OFS_CTRL      8'h00
`define SCCI_OFS_HDR       8'h04
`define SCCI_OFS_LEN       8'h08
`define SCCI_OFS_DATA      8'h0C
`define SCCI_OFS_STATUS    8'h10
`define SCCI_OFS_CARD_SEL  8'h18
`define SCCI_OFS_IRQ_STAT  8'h1C
`define SCCI_OFS_IRQ_MASK  8'h20
`define SCCI_OFS_REPLY0    8'h30
`define SCCI_OFS_REPLY1    8'h34
`define SCCI_OFS_REPLY2    8'h38
`define SCCI_OFS_REPLY3    8'h3C
`define SCCI_CLA           8'hFF
`define SCCI_INS_VERIFY    8'h20
`define SCCI_INS_FUSE      8'h05
`define SCCI_INS_INFO      8'h09
`define SCCI_VER_CNT_LEN   8'h08
`define SCCI_VER_KEY_ADDR  8'h0A
`define SCCI_VER_LEN       8'h02
`define SCCI_FUSE_LEN      8'h04
`define SCCI_FUSE_PIN_ON   8'h01
`define SCCI_INFO_LEN      8'h10
`define SCCI_SW_OK         16'h9000
`define SCCI_SW_NO_RETRY   16'h6300
`define SCCI_ERR_NONE      8'h00
`define SCCI_ERR_FORMAT    8'h03
`define SCCI_ERR_UNKNOWN   8'h04
`define SCCI_ERR_CARD_OP   8'h05
`define SCCI_TYPE_NONE     8'h00
`define SCCI_TYPE_MAX_SEQ  8'h09
`define SCCI_TYPE_MCU_T0   8'h0C
`define SCCI_TYPE_MCU_T1   8'h0D
`define SCCI_TYPE_BITMAP   16'h33FF
`define SCCI_STAT_ABSENT   8'h00
`define SCCI_STAT_INSERTED 8'h01
`define SCCI_STAT_POWERED  8'h03
`define SCCI_FW_VERSION    80'h0000_0000_0000_0000_0001
`define SCCI_MAX_CMD       8'h10
`define SCCI_MAX_RESP      8'h10
`define SCCI_IRQ_DONE      0
`define SCCI_IRQ_ERROR     1
`define SCCI_IRQ_FUSE      2
`endif

// ===== scci_pkg.sv
// types for the card command interpreter
package scci_pkg;
  typedef enum logic [2:0] {
    SCCI_OP_PRESENT,
    SCCI_OP_READ_CNT,
    SCCI_OP_WRITE_CNT,
    SCCI_OP_ERASE_CNT,
    SCCI_OP_FUSE
  } scci_op_t;
  typedef enum {
    SCCI_IDLE,
    SCCI_DECODE,
    SCCI_PRESENT,
    SCCI_READ_CNT,
    SCCI_WRITE_CNT,
    SCCI_ERASE_CNT,
    SCCI_FUSE,
    SCCI_FINISH
  } scci_state_t;
endpackage

// ===== scci_top_monitor.sv
// port checker for the card command interpreter
`timescale 1ns/10ps
`default_nettype none
module scci_top_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        card_req,
  input wire logic [2:0]  card_op,
  input wire logic [15:0] card_addr,
  input wire logic [15:0] card_wdata,
  input wire logic        card_fail,
  input wire logic [7:0]  card_aux,
  input wire logic        card_ack,
  input wire logic [7:0]  card_rdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence cnt_read;
    card_req && card_op == 3'd1 && card_ack && !card_fail;
  endsequence
  sequence bit_cleared;
    card_req && card_op == 3'd2 && card_ack && !card_fail;
  endsequence
  chk_ready_access: assert property (psel && !penable |=> pready)
    else $error("ready late");
  chk_ready_only: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_unmapped_err: assert property (psel && !penable && paddr > 8'h3C |=> pslverr)
    else $error("unmapped without error");
  chk_req_hold: assert property (card_req && !card_ack |=> card_req && $stable(card_op))
    else $error("card request not held");
  // the next step of a sequence may start at the ack edge, with a new op code
  chk_req_drop: assert property (card_req && card_ack |=> !card_req || card_op != $past(card_op))
    else $error("card request held after ack");
  chk_key_addr: assert property (card_req && card_op == 3'd0 |-> card_addr == 16'h000A)
    else $error("key address wrong");
  chk_counter_len: assert property (card_req && card_op == 3'd1 |-> card_aux == 8'h08)
    else $error("counter length wrong");
  chk_bit_write: assert property (cnt_read ##0 card_rdata != 8'h00 |-> ##[1:6] card_req && card_op == 3'd2)
    else $error("no counter bit write");
  chk_erase_after: assert property (bit_cleared |-> ##[1:6] card_req && card_op == 3'd3)
    else $error("no counter erase");
  chk_no_retry: assert property (cnt_read ##0 card_rdata == 8'h00 |=> !card_req [*4])
    else $error("card used without retries");
  chk_fuse_pin: assert property (card_req && card_op == 3'd4 |-> card_wdata[15:8] == 8'h01)
    else $error("fuse pin state wrong");
endmodule
bind scci_top scci_top_monitor u_mon (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .card_req, .card_op, .card_addr, .card_wdata, .card_fail, .card_aux, .card_ack,
  .card_rdata);
`default_nettype wire

// ===== scci_card_model.sv
// behavioural secure memory card behind the interpreter
`timescale 1ns/10ps
`default_nettype none
module scci_card_model #(
  parameter logic [15:0] KEY = 16'h0000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        card_req,
  input  wire logic [2:0]  card_op,
  input  wire logic [15:0] card_wdata,
  input  wire logic        fail_en,
  output logic             card_ack,
  output logic             card_fail,
  output logic      [7:0]  card_rdata
);
  logic [7:0] cnt;
  logic       ok_ff;
  logic       burned;
  int         wait_n;
  // random stall of 0..3 cycles; idle lines toggle so stale data never matches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_ack <= 1'b0;
      card_fail <= 1'b0;
      card_rdata <= 8'h00;
      wait_n <= 0;
    end else if (card_req && !card_ack && wait_n == 0) begin
      card_ack <= 1'b1;
      card_fail <= fail_en;
      card_rdata <= (card_op == 3'd1) ? cnt : ~card_rdata;
      wait_n <= $urandom_range(3, 0);
      case (card_op)
        3'd0: ok_ff <= (card_wdata == KEY);
        3'd2: cnt[card_wdata[2:0]] <= 1'b0;
        3'd3: if (ok_ff) cnt <= 8'hFF;
        3'd4: burned <= 1'b1;
        default: ;
      endcase
    end else begin
      card_ack <= 1'b0;
      card_fail <= ~card_fail;
      card_rdata <= ~card_rdata;
      if (card_req && wait_n > 0) wait_n <= wait_n - 1;
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the card command interpreter
`timescale 1ns/10ps
`default_nettype none
`include "scci_defs.svh"
module tb_top;
  localparam logic [7:0]  ST = `SCCI_OFS_STATUS;
  localparam logic [7:0]  SEL = `SCCI_OFS_CARD_SEL;
  localparam logic [31:0] VH = 32'h0A08_20FF;
  localparam logic [31:0] IH = 32'h0000_09FF;
  localparam logic [15:0] KEY = 16'h5A3C;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        card_present, card_powered, card_req, card_ack, card_fail, fail_en;
  logic [7:0]  paddr, card_aux, card_rdata, sel, c8;
  logic [2:0]  card_op;
  logic [15:0] card_addr, card_wdata, code;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [64:0] note_q[$];
  logic [64:0] note;
  int          n_fail, total_checks, n_req, n0;
  scci_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .card_present, .card_powered, .card_req, .card_op,
    .card_addr, .card_wdata, .card_aux, .card_ack, .card_fail, .card_rdata);
  scci_card_model #(.KEY(KEY)) u_card (.pclk, .presetn, .card_req, .card_op,
    .card_wdata, .fail_en, .card_ack, .card_fail, .card_rdata);
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // note goes in before the request so the watcher always finds it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, m, e,
                     input logic err);
    note_q.push_back({err, m, e & m});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed: only the watchdog ends a stuck access
    do begin
      @(posedge pclk);
    end while (!pready);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0000_0000, m, e, 1'b0);
  endtask
  task automatic cmd(input logic [31:0] hdr, len, data, input logic ie);
    wr(`SCCI_OFS_HDR, hdr);
    wr(`SCCI_OFS_LEN, len);
    wr(`SCCI_OFS_DATA, data);
    wr(`SCCI_OFS_CTRL, 32'h0000_0001);
    do begin
      rdc(`SCCI_OFS_CTRL, 32'h0000_0000, 32'h0000_0000);
    end while (rd[0]);
    chk({31'h0, irq}, {31'h0, ie}, "irq level");
    rdc(`SCCI_OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000, "irq after clear");
  endtask
  always @(posedge pclk) begin
    if (card_req && card_ack) n_req++;
    if (psel && penable && pready) begin
      note = note_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, note[64]}, "error flag");
      chk(prdata & note[63:32], note[31:0], "read data");
    end
  end
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #400000;
    n_fail++;
    $display("MISMATCH t=%0t watchdog", $time);
    final_report();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    card_present = 1'b1;
    card_powered = 1'b1;
    fail_en = 1'b0;
    seed = $urandom(45404);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(ST, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(SEL, 32'h0000_00FF, 32'h0000_0000);
    apb(1'b0, 8'h44, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b1);
    wr(`SCCI_OFS_IRQ_MASK, 32'h0000_0007);
    $display("test reset done");
    for (int s = 0; s < 3; s++) begin
      card_present <= (s > 0);
      card_powered <= (s == 2);
      cmd(IH, 32'h0000_0010, 32'h0000_0000, 1'b1);
      rdc(ST, 32'h00FF_FFFF, 32'h0000_9000);
      rdc(`SCCI_OFS_REPLY2, 32'hFFFF_0000, {`SCCI_MAX_RESP, `SCCI_MAX_CMD, 16'h0000});
      rdc(`SCCI_OFS_REPLY3, 32'hFFFF_FFFF, {8'((1 << s) - 1), 8'h00, `SCCI_TYPE_BITMAP});
    end
    $display("test info done");
    u_card.cnt = 8'h0F;
    cmd(VH, 32'h0000_0002, {16'h0000, KEY}, 1'b1);
    rdc(ST, 32'h00FF_FFFF, 32'h0000_9000);
    chk({24'h0, u_card.cnt}, 32'h0000_00FF, "counter erased");
    repeat (4) begin
      code = $urandom;
      code = code ^ 16'(code == KEY);
      c8 = 8'($urandom) | 8'h80;
      u_card.cnt = c8;
      cmd(VH, 32'h0000_0002, {16'h0000, code}, 1'b1);
      rdc(ST, 32'h00FF_FFFF, 32'h0000_9000);
      chk({24'h0, u_card.cnt}, {24'h0, c8 & (c8 - 8'h01)}, "one bit used");
    end
    u_card.cnt = 8'h00;
    n0 = n_req;
    cmd(VH, 32'h0000_0002, {16'h0000, KEY}, 1'b1);
    rdc(ST, 32'h00FF_FFFF, 32'h0000_6300);
    chk(32'(n_req - n0), 32'h0000_0002, "ops without retry");
    $display("test verify done");
    c8 = 8'h20;
    while (c8 == 8'h20 || c8 == 8'h05 || c8 == 8'h09) c8 = 8'($urandom);
    n0 = n_req;
    cmd({16'h0000, c8, 8'hFF}, 32'h0000_0000, 32'h0000_0000, 1'b1);
    rdc(ST, 32'h00FF_FFFF, 32'h0004_0000);
    cmd(32'h0000_05FF, 32'h0000_0004, 32'h0100_C905, 1'b1);
    rdc(ST, 32'h00FF_0000, 32'h0003_0000);
    chk(32'(n_req - n0), 32'h0000_0000, "card untouched");
    fail_en <= 1'b1;
    cmd(VH, 32'h0000_0002, {16'h0000, KEY}, 1'b1);
    rdc(ST, 32'h00FF_0000, 32'h0005_0000);
    fail_en <= 1'b0;
    card_present <= 1'b0;
    cmd(VH, 32'h0000_0002, {16'h0000, KEY}, 1'b1);
    rdc(ST, 32'h00FF_0000, 32'h0005_0000);
    card_present <= 1'b1;
    wr(`SCCI_OFS_IRQ_MASK, 32'h0000_0000);
    cmd(IH, 32'h0000_0010, 32'h0000_0000, 1'b0);
    wr(`SCCI_OFS_IRQ_MASK, 32'h0000_0007);
    $display("test errors done");
    cmd(32'h0000_05FF, 32'h0000_0004, 32'h0101_C905, 1'b1);
    rdc(ST, 32'hFFFF_FFFF, 32'h8000_9000);
    chk({31'h0, u_card.burned}, 32'h0000_0001, "fuse burned");
    sel = 8'h00;
    for (int c = 0; c < 16; c++) begin
      wr(SEL, 32'(c));
      if (c < 10 || c == 12 || c == 13) sel = 8'(c);
      rdc(SEL, 32'h0000_00FF, {24'h0, sel});
    end
    cmd(IH, 32'h0000_0010, 32'h0000_0000, 1'b1);
    rdc(ST, 32'h8000_0000, 32'h8000_0000);
    rdc(`SCCI_OFS_REPLY3, 32'h00FF_0000, {8'h00, sel, 16'h0000});
    $display("test fuse and select done");
    final_report();
  end
endmodule
`default_nettype wire
